//--- rtl/pbs_seq.sv
// band select sequencer: buffered frequency words, phase step, resync, core power
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_seq (
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  // register writes from the host
  input  wire pbs_pkg::pbs_wr_t       i_wr,
  // resync and phase configuration
  input  wire pbs_pkg::pbs_sync_cfg_t i_sync_cfg,
  input  wire logic [11:0]            i_phase_step,
  input  wire logic                   i_cmp_tick,
  // host pins: band code and buffer enable
  input  wire logic [1:0]             i_band_pin,
  input  wire logic                   i_buf_en_pin,
  // frequency state
  output var pbs_pkg::pbs_freq_t      o_freq_act,
  output logic                        o_freq_upd,
  // phase state
  output logic [11:0]                 o_phase,
  output logic                        o_phase_aligned,
  output logic                        o_sync,
  // core supply and buffer
  output logic [3:0]                  o_core_pwr,
  output logic                        o_buf_en
);

  // ****************************************
  // register writes
  // ****************************************
  pbs_pkg::pbs_freq_t freq_buf_r;
  pbs_pkg::pbs_freq_t freq_act_r;
  logic               freq_upd_r;
  wire                wr_r0;
  wire                wr_r1;
  wire                wr_r3;
  wire                wr_r6;

  // address decode
  assign wr_r0 = i_wr.vld && (i_wr.addr == `PBS_REG_R0);
  assign wr_r1 = i_wr.vld && (i_wr.addr == `PBS_REG_R1);
  assign wr_r3 = i_wr.vld && (i_wr.addr == `PBS_REG_R3);
  assign wr_r6 = i_wr.vld && (i_wr.addr == `PBS_REG_R6);

  // buffered words; only register 0 moves them to the active set
  // double buffered update
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      freq_buf_r <= {4{`PBS_WORD_RST}};
      freq_act_r <= {4{`PBS_WORD_RST}};
      freq_upd_r <= 1'b0;
    end
    else
    begin
      if (wr_r6)
        freq_buf_r.r6 <= i_wr.data;
      if (wr_r3)
        freq_buf_r.r3 <= i_wr.data;
      if (wr_r1)
        freq_buf_r.r1 <= i_wr.data;
      if (wr_r0)
      begin
        freq_buf_r.r0 <= i_wr.data;
        freq_act_r    <= {freq_buf_r.r6, freq_buf_r.r3, freq_buf_r.r1, i_wr.data};
      end
      freq_upd_r <= wr_r0;
    end
  end

  assign o_freq_act = freq_act_r;
  assign o_freq_upd = freq_upd_r;

  // ****************************************
  // phase step and resync
  // ****************************************
  logic [11:0] phase_r;
  logic        aligned_r;
  wire  [12:0] phase_sum;
  wire  [12:0] phase_wrap;
  wire  [11:0] phase_nxt;
  wire         sync_pls;

  pbs_sync_timer u_timer (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_cfg      (i_sync_cfg),
    .i_cmp_tick (i_cmp_tick),
    .o_sync     (sync_pls)
  );

  // step units are 1/4095 of a turn, so the sum wraps at 4095
  // modulo 4095 step
  assign phase_sum  = {1'b0, phase_r} + {1'b0, i_phase_step};
  assign phase_wrap = phase_sum - `PBS_PHASE_MOD;
  assign phase_nxt  = (phase_sum >= `PBS_PHASE_MOD) ? phase_wrap[11:0] : phase_sum[11:0];

  // offset only moves by steps, so it survives frequency changes
  // step per write
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      phase_r <= `PBS_PHASE_RST;
    else if (wr_r0)
      phase_r <= phase_nxt;
  end

  // a new frequency loses alignment until the next sync pulse
  // realign on sync
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      aligned_r <= 1'b0;
    else if (sync_pls && i_sync_cfg.en)
      aligned_r <= 1'b1;
    else if (wr_r0)
      aligned_r <= 1'b0;
  end

  assign o_phase         = phase_r;
  assign o_phase_aligned = aligned_r;
  assign o_sync          = sync_pls;

  // ****************************************
  // band select and buffer enable pins
  // ****************************************
  logic [1:0] band_s1_r;
  logic [1:0] band_s2_r;
  logic [1:0] band_s3_r;
  logic [1:0] band_r;
  logic       buf_s1_r;
  logic       buf_s2_r;
  logic       buf_s3_r;
  logic       buf_en_r;
  logic [3:0] core_r;
  wire  [3:0] core_dec;

  // three-stage synchronisers on host pins
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      band_s1_r <= `PBS_BAND_RST;
      band_s2_r <= `PBS_BAND_RST;
      band_s3_r <= `PBS_BAND_RST;
      buf_s1_r  <= 1'b0;
      buf_s2_r  <= 1'b0;
      buf_s3_r  <= 1'b0;
    end
    else
    begin
      band_s1_r <= i_band_pin;
      band_s2_r <= band_s1_r;
      band_s3_r <= band_s2_r;
      buf_s1_r  <= i_buf_en_pin;
      buf_s2_r  <= buf_s1_r;
      buf_s3_r  <= buf_s2_r;
    end
  end

  // take a change once stages two and three agree
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      band_r   <= `PBS_BAND_RST;
      buf_en_r <= 1'b0;
    end
    else
    begin
      if (band_s2_r == band_s3_r)
        band_r <= band_s3_r;
      if (buf_s2_r == buf_s3_r)
        buf_en_r <= buf_s3_r;
    end
  end

  // one-of-four decode: the switch feeds one core only
  // one-hot core supply
  assign core_dec = 4'h1 << band_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      core_r <= `PBS_CORE_RST;
    else
      core_r <= core_dec;
  end

  assign o_core_pwr = core_r;
  assign o_buf_en   = buf_en_r;

  // ****************************************
  // checks
  // ****************************************
  property p_core_onehot;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $onehot(o_core_pwr);
  endproperty
  a_core_onehot: assert property (p_core_onehot)
    else $error("core supply not exactly one");

  property p_act_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !wr_r0 |=> $stable(o_freq_act);
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("active words changed without register 0 write");

  property p_act_load;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_r0 |=> (o_freq_act.r0 == $past(i_wr.data)) && o_freq_upd
        && (o_freq_act.r6 == $past(freq_buf_r.r6));
  endproperty
  a_act_load: assert property (p_act_load)
    else $error("register 0 write did not apply buffered words");

  property p_phase_step;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_r0 |=> ({1'b0, o_phase} == {1'b0, $past(o_phase)} + {1'b0, $past(i_phase_step)})
        || ({1'b0, o_phase} + `PBS_PHASE_MOD
          == {1'b0, $past(o_phase)} + {1'b0, $past(i_phase_step)});
  endproperty
  a_phase_step: assert property (p_phase_step)
    else $error("phase did not advance by one step");

  property p_phase_range;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      {1'b0, o_phase} < `PBS_PHASE_MOD;
  endproperty
  a_phase_range: assert property (p_phase_range)
    else $error("phase outside one turn");

  property p_phase_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !wr_r0 |=> $stable(o_phase);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase moved without register 0 write");

  property p_align;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_sync && i_sync_cfg.en |=> o_phase_aligned;
  endproperty
  a_align: assert property (p_align)
    else $error("sync pulse did not realign phase");

endmodule : pbs_seq

`default_nettype wire

//--- rtl/pbs_defs.svh
// constants for the band select sequencer: register numbers, phase modulus, reset values
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

// synthesizer register numbers written by the host
`define PBS_REG_R0        3'h0
`define PBS_REG_R1        3'h1
`define PBS_REG_R3        3'h3
`define PBS_REG_R6        3'h6

// phase modulus: one full turn is this many step units
`define PBS_PHASE_MOD     13'h0FFF

// reset values
`define PBS_WORD_RST      32'h0000_0000
`define PBS_PHASE_RST     12'h000
`define PBS_BAND_RST      2'h0
`define PBS_CORE_RST      4'h1

`endif

//--- rtl/pbs_pkg.sv
// types shared by the band select sequencer files
package pbs_pkg;

  // one register write from the host
  typedef struct packed {
    logic        vld;
    logic [2:0]  addr;
    logic [31:0] data;
  } pbs_wr_t;

  // frequency word set, buffered or active
  typedef struct packed {
    logic [31:0] r6;
    logic [31:0] r3;
    logic [31:0] r1;
    logic [31:0] r0;
  } pbs_freq_t;

  // resync configuration
  typedef struct packed {
    logic        en;
    logic [11:0] cnt_a;
    logic [11:0] cnt_b;
  } pbs_sync_cfg_t;

endpackage : pbs_pkg

//--- rtl/pbs_sync_timer.sv
// resync timer: one pulse every count_a x count_b compare periods
`timescale 1ns/1ps
`default_nettype none

module pbs_sync_timer (
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // configuration and compare period tick
  input  wire pbs_pkg::pbs_sync_cfg_t i_cfg,
  input  wire logic                  i_cmp_tick,
  // sync pulse
  output logic                       o_sync
);

  logic [11:0] cnt_a_r;
  logic [11:0] cnt_b_r;
  logic        sync_r;
  wire         a_wrap;
  wire         b_wrap;

  // a zero count behaves as one
  assign a_wrap = (cnt_a_r + 12'h001 >= i_cfg.cnt_a);
  assign b_wrap = (cnt_b_r + 12'h001 >= i_cfg.cnt_b);

  // nested counters in compare periods
  // interval counting
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !i_cfg.en)
    begin
      cnt_a_r <= 12'h000;
      cnt_b_r <= 12'h000;
      sync_r  <= 1'b0;
    end
    else
    begin
      sync_r <= i_cmp_tick && a_wrap && b_wrap;
      if (i_cmp_tick)
      begin
        cnt_a_r <= a_wrap ? 12'h000 : cnt_a_r + 12'h001;
        if (a_wrap)
          cnt_b_r <= b_wrap ? 12'h000 : cnt_b_r + 12'h001;
      end
    end
  end

  assign o_sync = sync_r;

  // ****************************************
  // checks
  // ****************************************
  property p_sync_cause;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_sync |-> $past(i_cmp_tick) && $past(i_cfg.en);
  endproperty
  a_sync_cause: assert property (p_sync_cause)
    else $error("sync pulse without tick or enable");

  property p_sync_single;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_sync && i_cfg.en && (i_cfg.cnt_a > 12'h001) |=> !o_sync;
  endproperty
  a_sync_single: assert property (p_sync_single)
    else $error("sync pulses back to back with count above one");

endmodule : pbs_sync_timer

`default_nettype wire

//--- verification/pbs_host_model.sv
// host controller model: register write order, band and buffer pins
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_host_model (
  // clock
  input  wire logic            i_sys_clk,
  // writes and pins toward the sequencer
  output var pbs_pkg::pbs_wr_t o_wr,
  output logic [1:0]           o_band_pin,
  output logic                 o_buf_en_pin
);
  // band pins move about 600 ns after register 0, 120 cycles of 5 ns
  localparam int BAND_DLY = 120;
  // band edges in frequency units; plain defaults
  localparam int F_LO   = 1000;
  localparam int F_STEP = 1000;
  localparam int F_HI   = 5000;

  // sigma-delta modulator enable as the host keeps it
  logic sd_mod_en;

  // idle pins at time zero
  initial
  begin
    o_wr         = '0;
    o_band_pin   = 2'h0;
    o_buf_en_pin = 1'b0;
    sd_mod_en    = 1'b0;
  end

  // modulator on before resync or steps
  task link_up;
    @(negedge i_sys_clk);
    o_buf_en_pin = 1'b1;
    sd_mod_en    = 1'b1;
  endtask : link_up

  // band from frequency, 4 means out of range
  function automatic int band_for(input int f);
    int b;
    b = (f - F_LO) / F_STEP;
    if (f < F_LO || f >= F_HI)
      b = 4;
    return b;
  endfunction : band_for

  task put_words(input logic [31:0] d6, input logic [31:0] d3, input logic [31:0] d1);
    @(negedge i_sys_clk);
    o_wr = '{vld: 1'b1, addr: `PBS_REG_R6, data: d6};
    @(negedge i_sys_clk);
    o_wr = '{vld: 1'b1, addr: `PBS_REG_R3, data: d3};
    @(negedge i_sys_clk);
    o_wr = '{vld: 1'b1, addr: `PBS_REG_R1, data: d1};
    @(negedge i_sys_clk);
    o_wr = '0;
  endtask : put_words

  task put_r0(input logic [31:0] d0);
    @(negedge i_sys_clk);
    o_wr = '{vld: 1'b1, addr: `PBS_REG_R0, data: d0};
    @(negedge i_sys_clk);
    o_wr = '0;
  endtask : put_r0

  task move_band(input logic [1:0] b);
    repeat (BAND_DLY) @(negedge i_sys_clk);
    o_band_pin = b;
  endtask : move_band

  task request(input int f, input logic [31:0] w);
    if (band_for(f) < 4)
    begin
      put_words(w ^ 32'h6, w ^ 32'h3, w ^ 32'h1);
      put_r0(w);
      move_band(2'(band_for(f)));
    end
  endtask : request

endmodule : pbs_host_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the band select sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"
`define TB_CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t act=%h exp=%h", $time, (act), (exp)); end end

module testbench;
  logic                   i_sys_clk;
  logic                   i_rst_n;
  logic                   i_cmp_tick;
  pbs_pkg::pbs_sync_cfg_t i_sync_cfg;
  logic [11:0]            i_phase_step;
  pbs_pkg::pbs_wr_t       wr;
  logic [1:0]             band_pin;
  logic                   buf_en_pin;
  pbs_pkg::pbs_freq_t     freq_act;
  logic                   freq_upd, aligned, sync, buf_en;
  logic [11:0]            phase;
  logic [3:0]             core_pwr;
  logic [11:0]            steps [4] = '{12'h100, 12'hFA0, 12'hFFF, 12'h000};
  int                     err_total = 0;
  int                     n_checks = 0;
  int                     exp_ph = 0;

  pbs_host_model i_pbs_host_model (.i_sys_clk(i_sys_clk), .o_wr(wr), .o_band_pin(band_pin),
    .o_buf_en_pin(buf_en_pin));

  pbs_seq i_pbs_seq (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wr(wr),
    .i_sync_cfg(i_sync_cfg), .i_phase_step(i_phase_step), .i_cmp_tick(i_cmp_tick),
    .i_band_pin(band_pin), .i_buf_en_pin(buf_en_pin), .o_freq_act(freq_act),
    .o_freq_upd(freq_upd), .o_phase(phase), .o_phase_aligned(aligned), .o_sync(sync),
    .o_core_pwr(core_pwr), .o_buf_en(buf_en));

  // clock of 5 ns
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // outputs while reset is held, then buffer enable follows the pin
  task t_reset;
    `TB_CHK(core_pwr, `PBS_CORE_RST)
    `TB_CHK(freq_act, 128'h0)
    `TB_CHK(phase, `PBS_PHASE_RST)
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    i_pbs_host_model.link_up;
    repeat (6) @(negedge i_sys_clk);
    `TB_CHK(buf_en, 1'b1)
  endtask : t_reset

  // compare ticks, no pulse may appear meanwhile
  task pulse_ticks(input int n);
    repeat (n)
    begin
      @(negedge i_sys_clk);
      `TB_CHK(sync, 1'b0)
      i_cmp_tick = 1'b1;
      @(negedge i_sys_clk);
      i_cmp_tick = 1'b0;
    end
  endtask : pulse_ticks

  // disabled timer stays quiet, enabled one pulses after 2 x 2 ticks
  task t_resync;
    pulse_ticks(4);
    `TB_CHK(i_pbs_host_model.sd_mod_en, 1'b1)
    i_sync_cfg.en = 1'b1;
    pulse_ticks(4);
    `TB_CHK(sync, 1'b1)
    @(negedge i_sys_clk);
    `TB_CHK(sync, 1'b0)
    `TB_CHK(aligned, 1'b1)
  endtask : t_resync

  // buffered words, register 0 commit, phase step, then band move
  task t_update(input logic [1:0] b, input logic [11:0] step);
    logic [31:0]        w;
    pbs_pkg::pbs_freq_t old;
    old = freq_act;
    w = 32'h1234_0000 | {30'h0, b};
    i_phase_step = step;
    exp_ph = (exp_ph + int'(step)) % 4095;
    `TB_CHK(i_pbs_host_model.sd_mod_en, 1'b1)
    i_pbs_host_model.put_words(w ^ 32'h6, w ^ 32'h3, w ^ 32'h1);
    `TB_CHK(freq_act, old)
    `TB_CHK(freq_upd, 1'b0)
    i_pbs_host_model.put_r0(w);
    `TB_CHK(freq_upd, 1'b1)
    `TB_CHK(freq_act, {w ^ 32'h6, w ^ 32'h3, w ^ 32'h1, w})
    `TB_CHK(phase, 12'(exp_ph))
    `TB_CHK(aligned, 1'b0)
    @(negedge i_sys_clk);
    `TB_CHK(freq_upd, 1'b0)
    i_pbs_host_model.move_band(b);
    repeat (6) @(negedge i_sys_clk);
    `TB_CHK(core_pwr, 4'h1 << b)
  endtask : t_update

  // refused requests write nothing; repeating the last words at a zero step keeps the phase
  task t_reject;
    pbs_pkg::pbs_freq_t old;
    old = freq_act;
    i_pbs_host_model.request(500, 32'hDEAD_0000);
    i_pbs_host_model.request(9000, 32'hDEAD_0000);
    repeat (4) @(negedge i_sys_clk);
    `TB_CHK(freq_act, old)
    `TB_CHK(freq_upd, 1'b0)
    `TB_CHK(phase, 12'(exp_ph))
    i_pbs_host_model.request(1500, old.r0);
    repeat (6) @(negedge i_sys_clk);
    `TB_CHK(freq_act, old)
    `TB_CHK(phase, 12'(exp_ph))
    `TB_CHK(core_pwr, 4'h1)
  endtask : t_reject

  // main sequence
  initial
  begin
    i_rst_n      = 1'b0;
    i_cmp_tick   = 1'b0;
    i_phase_step = 12'h000;
    // interval of four ticks outlasts the modelled settling
    i_sync_cfg   = '{en: 1'b0, cnt_a: 12'h002, cnt_b: 12'h002};
    repeat (8) @(negedge i_sys_clk);
    t_reset;
    t_resync;
    for (int k = 0; k < 4; k++)
      t_update(2'(k + 2), steps[k]);
    t_reject;
    print_verdict;
  end

  // watchdog against a hang
  initial
  begin
    #20000;
    err_total++;
    print_verdict;
  end

endmodule : testbench
`default_nettype wire
